// ==== azx_core.sv ====
// Execution of trap, exclusive-OR and zero-and-load accumulator instructions
`timescale 1ns/10ps
module azx_core (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_word,
	input  wire logic [15:0] dmem_rdata,
	input  wire logic        sign_extension_mode,
	output logic             busy,
	output logic [15:0]      pc,
	output logic [31:0]      acc,
	output logic             dmem_rd,
	output logic             dmem_indirect,
	output logic [6:0]       dmem_offset,
	output logic             stack_push,
	output logic [15:0]      stack_top,
	output logic             illegal
);
	// ****************************************
	// State
	// ****************************************
	typedef enum logic [2:0] {
		OP_NONE  = 3'b000,
		OP_XOR   = 3'b001,
		OP_LHIGH = 3'b010,
		OP_LLOW  = 3'b011,
		OP_LRND  = 3'b100
	} azx_op_e;

	typedef struct packed {
		azx_pkg::azx_state_e st;
		azx_op_e             op;
		logic [3:0]          shift;
		logic [15:0]         pc;
		logic [31:0]         acc;
		logic                busy;
		logic                rd;
		logic                ind;
		logic [6:0]          off;
		logic                push;
		logic                ill;
	} azx_core_s;

	azx_core_s s_q;
	azx_core_s s_d;

	azx_stack_if stk ();

	azx_stack u_stack (
		.clk  (clk),
		.srst (srst),
		.st   (stk)
	);

	// ****************************************
	// Decode
	// ****************************************
	// Whole words are matched before byte patterns, so the trap and clear
	// words can never be taken for a memory reference.
	logic    dec_trap;
	logic    dec_clear;
	logic    dec_xor_imm;
	logic    dec_mem;
	azx_op_e dec_op;

	always_comb begin
		dec_trap    = (instr_word == azx_pkg::OP_TRAP);
		dec_clear   = (instr_word == azx_pkg::OP_CLEAR_ACC);
		dec_xor_imm = (instr_word[15:12] == azx_pkg::XOR_IMM_HI) &&
			(instr_word[7:0] == azx_pkg::XOR_IMM_LO);
		dec_mem     = 1'b1;
		case (instr_word[15:8])
			azx_pkg::OP_XOR_DM:     dec_op = OP_XOR;
			azx_pkg::OP_LOAD_HIGH:  dec_op = OP_LHIGH;
			azx_pkg::OP_LOAD_LOW:   dec_op = OP_LLOW;
			azx_pkg::OP_LOAD_ROUND: dec_op = OP_LRND;
			default: begin
				dec_op  = OP_NONE;
				dec_mem = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Accumulator results
	// ****************************************
	// Every candidate is formed each cycle; the state machine only picks one.
	logic [31:0] imm_shifted;
	logic [31:0] res_imm;
	logic [31:0] res_xor;
	logic [31:0] res_high;
	logic [31:0] res_low;
	logic [31:0] res_round;

	always_comb begin
		imm_shifted = {16'h0000, instr_word} << s_q.shift;
		// A 16-bit constant shifted by at most 15 never reaches bit 31
		res_imm     = {s_q.acc[31], s_q.acc[30:0] ^ imm_shifted[30:0]};
		res_xor     = {s_q.acc[31:16], s_q.acc[15:0] ^ dmem_rdata};
		res_high    = {dmem_rdata, 16'h0000};
		res_low     = {16'h0000, dmem_rdata};
		res_round   = {dmem_rdata, azx_pkg::ROUND_HALF};
	end

	// ****************************************
	// Next state
	// ****************************************
	// The memory word is taken at the edge that closes the read strobe's cycle.
	// sign_extension_mode is deliberately ignored by every path here.
	always_comb begin
		s_d     = s_q;
		s_d.rd   = 1'b0;
		s_d.push = 1'b0;
		s_d.ill  = 1'b0;
		case (s_q.st)
			azx_pkg::AZX_IDLE: begin
				if (instr_valid) begin
					s_d.ind = instr_word[7];
					s_d.off = instr_word[6:0];
					s_d.pc  = s_q.pc + 16'h1;
					if (dec_trap) begin
						s_d.push = 1'b1;
						s_d.pc   = azx_pkg::TRAP_VECTOR;
					end else if (dec_clear) begin
						s_d.acc = azx_pkg::ACC_RESET;
					end else if (dec_xor_imm) begin
						s_d.shift = instr_word[11:8];
						s_d.busy  = 1'b1;
						s_d.st    = azx_pkg::AZX_IMM;
					end else if (dec_mem) begin
						s_d.op   = dec_op;
						s_d.rd   = 1'b1;
						s_d.busy = 1'b1;
						s_d.st   = azx_pkg::AZX_DONE;
					end else begin
						// Unknown word: flag it and hold the program counter
						s_d.op  = OP_NONE;
						s_d.ill = 1'b1;
						s_d.pc  = s_q.pc;
					end
				end
			end
			azx_pkg::AZX_IMM: begin
				// Second word; bit 31 is kept, as the shifted constant is 31 bits wide
				if (instr_valid) begin
					s_d.acc      = res_imm;
					s_d.pc       = s_q.pc + 16'h1;
					s_d.busy     = 1'b0;
					s_d.st       = azx_pkg::AZX_IDLE;
				end
			end
			azx_pkg::AZX_DONE: begin
				s_d.busy = 1'b0;
				s_d.st   = azx_pkg::AZX_IDLE;
				case (s_q.op)
					OP_XOR:   s_d.acc = res_xor;
					OP_LHIGH: s_d.acc = res_high;
					OP_LLOW:  s_d.acc = res_low;
					OP_LRND:  s_d.acc = res_round;
					default:  s_d.acc = s_q.acc;
				endcase
			end
			default: s_d.st = azx_pkg::AZX_IDLE;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	// Reset clears every field; the return stack resets itself.
	always_ff @(posedge clk) begin
		if (srst) begin
			s_q.st    <= azx_pkg::AZX_IDLE;
			s_q.op    <= OP_NONE;
			s_q.shift <= 4'h0;
			s_q.pc    <= azx_pkg::PC_RESET;
			s_q.acc   <= azx_pkg::ACC_RESET;
			s_q.busy  <= 1'b0;
			s_q.rd    <= 1'b0;
			s_q.ind   <= 1'b0;
			s_q.off   <= 7'h00;
			s_q.push  <= 1'b0;
			s_q.ill   <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Return stack
	// ****************************************
	// Nothing pops here; the return path lives outside this block.
	// Push the return address computed before the vector load
	assign stk.push  = s_d.push;
	assign stk.pop   = 1'b0;
	assign stk.wdata = s_q.pc + 16'h1;

	// ****************************************
	// Outputs
	// ****************************************
	// Every output is a register bit, so nothing here can glitch.
	assign busy          = s_q.busy;
	assign pc            = s_q.pc;
	assign acc           = s_q.acc;
	assign dmem_rd       = s_q.rd;
	assign dmem_indirect = s_q.ind;
	assign dmem_offset   = s_q.off;
	assign stack_push    = s_q.push;
	assign stack_top     = stk.top;
	assign illegal       = s_q.ill;
endmodule // azx_core

// ==== azx_core_asserts.sv ====
// Checker of the accumulator, exclusive-OR and trap block
`timescale 1ns/10ps
module azx_core_asserts (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [15:0] dmem_rdata,
	input wire logic        busy,
	input wire logic [15:0] pc,
	input wire logic [31:0] acc,
	input wire logic        dmem_rd,
	input wire logic        dmem_indirect,
	input wire logic [6:0]  dmem_offset,
	input wire logic        stack_push,
	input wire logic [15:0] stack_top,
	input wire logic        illegal
);
	logic       tk;
	logic [7:0] op;
	logic       mem_op;
	logic       xk;
	assign tk = instr_valid && !busy;
	assign op = instr_word[15:8];
	assign mem_op = op == 8'h4C || op == 8'h40 || op == 8'h41 || op == 8'h7A;
	assign xk = instr_word[15:12] == 4'hD && instr_word[7:0] == 8'h06;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	AST_TRAP_PC: assert property (tk && instr_word == 16'hCE1E |=> pc == 16'h001E)
		else $error("trap vector wrong");
	AST_TRAP_PUSH: assert property (tk && instr_word == 16'hCE1E
		|=> stack_push ##1 stack_top == $past(pc, 2) + 16'h0001) else $error("trap push wrong");
	AST_LOAD_HIGH: assert property (tk && op == 8'h40
		|=> dmem_rd ##1 acc == {$past(dmem_rdata), 16'h0000}) else $error("load high wrong");
	AST_LOAD_LOW: assert property (tk && op == 8'h41
		|=> dmem_rd ##1 acc == {16'h0000, $past(dmem_rdata)}) else $error("load low wrong");
	AST_LOAD_ROUND: assert property (tk && op == 8'h7A
		|=> dmem_rd ##1 acc == {$past(dmem_rdata), 16'h8000}) else $error("round wrong");
	AST_XOR_MEM: assert property (tk && op == 8'h4C
		|=> dmem_rd && dmem_offset == $past(instr_word[6:0])
		##1 acc == {$past(acc[31:16], 2), $past(acc[15:0], 2) ^ $past(dmem_rdata)})
		else $error("memory xor wrong");
	AST_XOR_IMM: assert property (tk && xk |=> busy and (instr_valid |=>
		(acc ^ $past(acc, 2)) == (({16'h0000, $past(instr_word)} << $past(instr_word[11:8], 2))
		& 32'h7FFF_FFFF))) else $error("immediate xor wrong");
	AST_MEM_ADDR: assert property (tk && mem_op
		|=> dmem_indirect == $past(instr_word[7])) else $error("indirect select wrong");
	AST_ILLEGAL: assert property (tk && !mem_op && !xk && instr_word != 16'hCE1E
		&& instr_word != 16'hCA00 |=> illegal && !busy && pc == $past(pc))
		else $error("unknown word not flagged");
	AST_CLEAR: assert property (tk && instr_word == 16'hCA00 |=> acc == 32'h0)
		else $error("clear wrong");
endmodule // azx_core_asserts

// ==== azx_pkg.sv ====
// Package for the accumulator load, exclusive-OR and trap execution block
package azx_pkg;
	// ****************************************
	// Opcode patterns: upper bytes, whole words and immediate-form fields
	// ****************************************
	localparam logic [7:0] OP_XOR_DM     = 8'h4C;
	localparam logic [7:0] OP_LOAD_HIGH  = 8'h40;
	localparam logic [7:0] OP_LOAD_LOW   = 8'h41;
	localparam logic [7:0] OP_LOAD_ROUND = 8'h7A;
	localparam logic [15:0] OP_TRAP      = 16'hCE1E;
	localparam logic [15:0] OP_CLEAR_ACC = 16'hCA00;
	localparam logic [3:0]  XOR_IMM_HI   = 4'hD;
	localparam logic [7:0]  XOR_IMM_LO   = 8'h06;

	// ****************************************
	// Fixed values
	// ****************************************
	localparam logic [15:0] TRAP_VECTOR  = 16'h001E;
	localparam logic [15:0] ROUND_HALF   = 16'h8000;
	localparam logic [15:0] PC_RESET     = 16'h0000;
	localparam logic [31:0] ACC_RESET    = 32'h0000_0000;
	localparam int          STACK_DEPTH  = 8;
	localparam logic [2:0]  SP_RESET     = 3'h0;

	typedef enum logic [1:0] {
		AZX_IDLE  = 2'b00,
		AZX_IMM   = 2'b01,
		AZX_DONE  = 2'b10
	} azx_state_e;
endpackage

// ==== azx_stack.sv ====
// Hardware return stack with registered top-of-stack output
`timescale 1ns/10ps
module azx_stack (
	input  wire logic clk,
	input  wire logic srst,
	azx_stack_if.mem  st
);
	typedef struct packed {
		logic [azx_pkg::STACK_DEPTH-1:0][15:0] mem;
		logic [2:0]                            sp;
		logic [15:0]                           top;
	} azx_stk_s;

	azx_stk_s s_q;
	azx_stk_s s_d;

	always_comb begin
		logic [2:0] idx;
		idx = 3'h0;
		s_d = s_q;
		if (st.push) begin
			s_d.mem[s_q.sp] = st.wdata;
			s_d.sp          = s_q.sp + 3'h1;
			s_d.top         = st.wdata;
		end else if (st.pop) begin
			idx     = s_q.sp - 3'h1;
			s_d.sp  = idx;
			s_d.top = s_q.mem[idx - 3'h1];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q.sp  <= azx_pkg::SP_RESET;
			s_q.top <= 16'h0000;
			s_q.mem <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign st.top = s_q.top;
endmodule // azx_stack

// ==== azx_stack_if.sv ====
// Interface carrying push and pop traffic to the return stack
`timescale 1ns/10ps
interface azx_stack_if;
	logic        push;
	logic        pop;
	logic [15:0] wdata;
	logic [15:0] top;
	modport core (output push, output pop, output wdata, input top);
	modport mem  (input push, input pop, input wdata, output top);
endinterface

// ==== tb_azx_core.sv ====
// Testbench of the accumulator, exclusive-OR and trap block
`timescale 1ns/10ps
module tb_azx_core;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        instr_valid = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	logic [15:0] dmem_rdata = 16'h8001;
	logic        sign_extension_mode = 1'b1;
	logic        busy, dmem_rd, dmem_indirect, stack_push, illegal;
	logic [15:0] pc, stack_top;
	logic [6:0]  dmem_offset;
	logic [31:0] acc;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cyc = 0;
	always #5 clk = ~clk;
	azx_core uut (.clk(clk), .srst(srst), .instr_valid(instr_valid), .instr_word(instr_word),
		.dmem_rdata(dmem_rdata), .sign_extension_mode(sign_extension_mode), .busy(busy),
		.pc(pc), .acc(acc), .dmem_rd(dmem_rd), .dmem_indirect(dmem_indirect),
		.dmem_offset(dmem_offset), .stack_push(stack_push), .stack_top(stack_top),
		.illegal(illegal));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Second word only stays valid for the two-word form
	task automatic issue(input logic [15:0] w, input logic [15:0] w2, input logic two);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		@(posedge clk);
		instr_valid <= two;
		instr_word <= w2;
		@(posedge clk);
		instr_valid <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic results();
		$display("errors=%0d checks=%0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic t_trap();
		issue(16'hCE1E, 16'h0000, 1'b0);
		cmp({16'h0000, pc}, 32'h1E);
		cmp({16'h0000, stack_top}, 32'h1);
		issue(16'hCE1E, 16'h0000, 1'b0);
		cmp({16'h0000, stack_top}, 32'h1F);
	endtask
	// Sign mode held set: none of these loads may extend
	task automatic t_loads();
		issue(16'h407F, 16'h0000, 1'b0);
		cmp(acc, 32'h8001_0000);
		cmp({24'h00_0000, dmem_indirect, dmem_offset}, 32'h7F);
		issue(16'h4101, 16'h0000, 1'b0);
		cmp(acc, 32'h0000_8001);
		cmp({24'h00_0000, dmem_indirect, dmem_offset}, 32'h01);
		issue(16'h7A85, 16'h0000, 1'b0);
		cmp(acc, 32'h8001_8000);
		cmp({24'h00_0000, dmem_indirect, dmem_offset}, 32'h85);
	endtask
	// Sign mode cleared here: the results must not change with it
	task automatic t_xor();
		@(posedge clk);
		dmem_rdata <= 16'hFFFF;
		sign_extension_mode <= 1'b0;
		issue(16'h4CFF, 16'h0000, 1'b0);
		cmp(acc, 32'h8001_7FFF);
		cmp({24'h00_0000, dmem_indirect, dmem_offset}, 32'hFF);
		issue(16'hDF06, 16'hFFFF, 1'b1);
		cmp(acc, 32'hFFFE_FFFF);
		issue(16'hCA00, 16'h0000, 1'b0);
		cmp(acc, 32'h0);
	endtask
	// Unknown word: flagged for one cycle, program counter held
	task automatic t_illegal();
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_word <= 16'h4200;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		cmp({31'h0, illegal}, 32'h1);
		cmp({16'h0000, pc}, 32'h25);
		@(posedge clk);
		#1;
		cmp({31'h0, illegal}, 32'h0);
	endtask
	// ****************************************
	// Hang guard and main sequence
	// ****************************************
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 400) begin
			error_cnt++;
			results();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		t_trap();
		t_loads();
		t_xor();
		t_illegal();
		results();
	end
endmodule // tb_azx_core
bind azx_core azx_core_asserts u_chk (.clk(clk), .srst(srst), .instr_valid(instr_valid),
	.instr_word(instr_word), .dmem_rdata(dmem_rdata), .busy(busy), .pc(pc), .acc(acc),
	.dmem_rd(dmem_rd), .dmem_indirect(dmem_indirect), .dmem_offset(dmem_offset),
	.stack_push(stack_push), .stack_top(stack_top), .illegal(illegal));
